//--- rsvb_bank.sv
// Register bank with reserved-one and reserved-zero bit handling.
// Assumes a simple synchronous request port driven by logic on i_ref_clk.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Hardwired reserved-one bit reads 1 and ignores writes.
// - Indirect update forces writable reserved-one bits to 1.
// - Writable reserved-one bit reads last stored value, direct or indirect.
// - Unwritten reserved bit reads its reset value.
// - Direct write updates dedicated storage for writable reserved-one bits.
// - Reserved-one stored value affects only readback.
// - Hardwired or writable form chosen per field.
// - Context-reserved bit reads last stored value regardless of context.
// - Always-reserved bits may be stored or ignored.
// - Read-only reserved-one bit reads as 1.
// - Reserved positions: zero in RW registers, defined value in RO.
// - Arbitrary read values reveal no hidden state.
// - 32-bit words, aligned when byte address is multiple of 4.
// - Instance selector picks configured and described instance.
// - Reserved-zero: hardwired reads 0; indirect write forces 0.
module rsvb_bank
  import rsvb_pkg::*;
#(
  parameter logic [WORD_W-1:0] P_ONE_WR  = CFG_ONE_WR,
  parameter logic [WORD_W-1:0] P_ZERO_WR = CFG_ZERO_WR,
  parameter int unsigned       P_INST    = NUM_INST
)
(
  input  wire logic              i_ref_clk,
  input  wire logic              i_reset,
  input  wire logic              i_req,
  input  wire logic              i_wr,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [WORD_W-1:0] i_wdata,
  input  wire logic              i_ind_wr,
  input  wire logic [WORD_W-1:0] i_ind_data,
  output var  logic              o_ack,
  output var  logic              o_err,
  output var  logic [WORD_W-1:0] o_rdata,
  output var  logic [WORD_W-1:0] o_cfg_func,
  output var  logic [RIS_W-1:0]  o_sel_inst
);

  // Storage mask: functional bits plus writable reserved bits
  localparam logic [WORD_W-1:0] STORE_MASK =
    CFG_FUNC_MASK | (P_ONE_WR & CFG_ONE_MASK) | (P_ZERO_WR & CFG_ZERO_MASK);
  localparam logic [WORD_W-1:0] HARD_ONE = CFG_ONE_MASK & ~P_ONE_WR;

  // Merge a written word with the reserved-bit policy
  function automatic logic [WORD_W-1:0] fold_rd(
    input logic [WORD_W-1:0] stored
  );
    fold_rd = (stored & STORE_MASK) | HARD_ONE;
  endfunction

  logic [WORD_W-1:0] cfg_q [P_INST];
  logic [WORD_W-1:0] psel_q;
  logic [WORD_W-1:0] ctrl_q;
  logic              ack_q;
  logic              err_q;
  logic [WORD_W-1:0] rdata_q;
  logic [WORD_W-1:0] func_q;
  logic [RIS_W-1:0]  inst_q;

  // Address decode; misaligned byte address is refused
  wire logic              aligned = (i_addr[WORD_LSB-1:0] == 2'b00);
  wire logic [IDX_W-1:0]  idx     = i_addr[WORD_LSB+IDX_W-1:WORD_LSB];
  wire logic              mapped  =
    (i_addr[ADDR_W-1:WORD_LSB+IDX_W] == '0);
  wire logic              ok      = i_req & aligned & mapped;
  wire logic              wr_ok   = ok & i_wr;
  wire logic [RIS_W-1:0]  resource_instance_selector     = psel_q[RIS_LSB+RIS_W-1:RIS_LSB];
  wire logic              ctx_res = ctrl_q[0];
  wire logic              inst_ok = (32'(resource_instance_selector) < P_INST);
  wire logic [WORD_W-1:0] cfg_cur = inst_ok ? cfg_q[resource_instance_selector] : CFG_RST;

  // Direct write keeps written values in storage bits
  wire logic [WORD_W-1:0] cfg_dir = i_wdata & STORE_MASK;
  // Indirect update forces reserved storage to its reserved value
  wire logic [WORD_W-1:0] cfg_ind =
    ((i_ind_data & CFG_FUNC_MASK & ~(ctx_res ? CFG_CTX_MASK : ZERO_WORD))
     | (ctx_res ? CFG_CTX_MASK : (i_ind_data & CFG_CTX_MASK))
     | (P_ONE_WR & CFG_ONE_MASK)) & STORE_MASK;

  // Read mux; read-only word shows defined value in reserved bits
  wire logic [WORD_W-1:0] rd_mux =
    (idx == IDX_PART_SEL) ? psel_q :
    (idx == IDX_CFG)      ? fold_rd(cfg_cur) :
    (idx == IDX_ID)       ? (ID_BASE | ID_RO_ONE | 32'(resource_instance_selector)) :
                            ctrl_q;

  // Function bits exported; reserved bits masked out, context bits masked out in context 1
  wire logic [WORD_W-1:0] func_d =
    cfg_cur & CFG_FUNC_MASK & ~(ctx_res ? CFG_CTX_MASK : ZERO_WORD);

  // Per-instance configuration storage
  genvar g;
  generate
    for (g = 0; g < P_INST; g++)
    begin : g_inst
      always_ff @(posedge i_ref_clk)
      begin
        if (i_reset)
          cfg_q[g] <= CFG_RST;
        else if (wr_ok && idx == IDX_CFG && 32'(resource_instance_selector) == g)
          cfg_q[g] <= cfg_dir;
        else if (i_ind_wr && 32'(resource_instance_selector) == g)
          cfg_q[g] <= cfg_ind;
      end
    end
  endgenerate

  // Select and control words; reserved positions kept zero
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      psel_q <= ZERO_WORD;
      ctrl_q <= ZERO_WORD;
    end
    else if (wr_ok && idx == IDX_PART_SEL)
      psel_q <= i_wdata & PSEL_MASK;
    else if (wr_ok && idx == IDX_CTRL)
      ctrl_q <= i_wdata & CTRL_MASK;
  end

  // Answer one cycle after request; reads of ID ignore writes
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      ack_q   <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= ZERO_WORD;
      func_q  <= ZERO_WORD;
      inst_q  <= '0;
    end
    else
    begin
      ack_q   <= i_req;
      err_q   <= i_req & ~(aligned & mapped);
      rdata_q <= (ok && !i_wr) ? rd_mux : ZERO_WORD;
      func_q  <= func_d;
      inst_q  <= resource_instance_selector;
    end
  end

  assign o_ack      = ack_q;
  assign o_err      = err_q;
  assign o_rdata    = rdata_q;
  assign o_cfg_func = func_q;
  assign o_sel_inst = inst_q;

endmodule // rsvb_bank
`default_nettype wire

//--- rsvb_pkg.sv
// Package for the reserved-bit register bank: word layout, bit masks,
// reset values and the partition-select field layout.
// Assumes one 32-bit word per register, word aligned.
package rsvb_pkg;
  localparam int unsigned WORD_W      = 32;
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned WORD_LSB    = 2;
  localparam int unsigned NUM_REGS    = 4;
  localparam int unsigned IDX_W       = 2;
  localparam int unsigned RIS_W       = 4;
  localparam int unsigned NUM_INST    = 16;
  // Register indices
  localparam logic [IDX_W-1:0] IDX_PART_SEL = 2'h0;
  localparam logic [IDX_W-1:0] IDX_CFG      = 2'h1;
  localparam logic [IDX_W-1:0] IDX_ID       = 2'h2;
  localparam logic [IDX_W-1:0] IDX_CTRL     = 2'h3;
  // Partition-select fields
  localparam int unsigned PARTNUM_LSB = 0;
  localparam int unsigned PARTNUM_W   = 16;
  localparam int unsigned RIS_LSB     = 24;
  // Functional bits of the configuration word
  localparam logic [WORD_W-1:0] CFG_FUNC_MASK = 32'h0000_ffff;
  // Reserved-one bits: all of them, and which are writable storage
  localparam logic [WORD_W-1:0] CFG_ONE_MASK  = 32'h00ff_0000;
  localparam logic [WORD_W-1:0] CFG_ONE_WR    = 32'h000f_0000;
  // Reserved-zero bits: the rest; writable subset
  localparam logic [WORD_W-1:0] CFG_ZERO_MASK = 32'hff00_0000;
  localparam logic [WORD_W-1:0] CFG_ZERO_WR   = 32'h0f00_0000;
  // Context bit: in context 1 these bits are reserved-one, else functional
  localparam logic [WORD_W-1:0] CFG_CTX_MASK  = 32'h0000_f000;
  localparam logic [WORD_W-1:0] CFG_RST       = 32'h00ff_0000;
  localparam logic [WORD_W-1:0] PSEL_MASK     = 32'h0f00_ffff;
  localparam logic [WORD_W-1:0] CTRL_MASK     = 32'h0000_0001;
  localparam logic [WORD_W-1:0] ZERO_WORD     = 32'h0000_0000;
  // Read-only identification word, arbitrary neutral value
  localparam logic [WORD_W-1:0] ID_BASE       = 32'h0000_1000;
  localparam logic [WORD_W-1:0] ID_RO_ONE     = 32'h8000_0000;
endpackage

//--- rsvb_bank_assertions.sv
// Checker for the reserved-bit register bank, ports of rsvb_bank only.
// Assumes the one-cycle ack contract on i_ref_clk.
`timescale 1ns/1ps
`default_nettype none
module rsvb_bank_assertions
  import rsvb_pkg::*;
(
  input wire logic              i_ref_clk,
  input wire logic              i_reset,
  input wire logic              i_req,
  input wire logic              i_wr,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic              o_ack,
  input wire logic              o_err,
  input wire logic [WORD_W-1:0] o_rdata,
  input wire logic [WORD_W-1:0] o_cfg_func,
  input wire logic [RIS_W-1:0]  o_sel_inst
);
  logic              rd_q;
  logic [ADDR_W-1:0] a_q;
  wire               ok = o_ack && !o_err && rd_q;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  // Remember the request so its answer can be judged
  always_ff @(posedge i_ref_clk)
  begin
    rd_q <= i_req && !i_wr;
    a_q  <= i_addr;
  end
  AST_ACK: assert property (i_req |=> o_ack)
    else $error("ack missing");
  AST_IDLE: assert property (!i_req |=> !o_ack && !o_err)
    else $error("stray ack");
  AST_MISAL: assert property (i_req && i_addr[1:0] != 2'h0 |=>
    o_err && o_rdata == ZERO_WORD) else $error("misaligned taken");
  AST_HW1: assert property (ok && a_q == 8'h04 |->
    o_rdata[23:20] == 4'hf) else $error("fixed ones lost");
  AST_HW0: assert property (ok && a_q == 8'h04 |->
    o_rdata[31:28] == 4'h0) else $error("fixed zeros lost");
  AST_ROONE: assert property (ok && a_q == 8'h08 |->
    o_rdata[31] && o_rdata[3:0] == o_sel_inst) else $error("id bad");
  AST_PSEL: assert property (ok && a_q == 8'h00 |->
    (o_rdata & ~PSEL_MASK) == ZERO_WORD) else $error("psel spare");
  AST_CTL: assert property (ok && a_q == 8'h0c |->
    (o_rdata & ~CTRL_MASK) == ZERO_WORD) else $error("ctrl spare");
  AST_FUNC: assert property (o_cfg_func[31:16] == 16'h0)
    else $error("reserved bits leak");
  cover property (o_err);
  cover property (ok && a_q == 8'h04);
  cover property (i_req && i_wr && i_addr == 8'h0c);
endmodule // rsvb_bank_assertions
`default_nettype wire

//--- reserved_bit_field_handling_test.sv
// Random bench for the reserved-bit register bank.
// Assumes NUM_INST selectable instances and a one-cycle ack.
`timescale 1ns/1ps
`default_nettype none
module reserved_bit_field_handling_test;
  import rsvb_pkg::*;
  logic i_ref_clk = 0, i_reset = 1, i_req = 0, i_wr = 0, i_ind_wr = 0;
  logic [7:0]  i_addr = 0;
  logic [31:0] i_wdata = 0, i_ind_data = 0, o_rdata, o_cfg_func;
  logic o_ack, o_err, ctx, e;
  logic [3:0]  o_sel_inst, resource_instance_selector;
  logic [31:0] s = 35651, v, r, cfg [16];
  int n_fail = 0, total_checks = 0;
  always #2.5 i_ref_clk = ~i_ref_clk;
  rsvb_bank rsvb_bank_i (.i_ref_clk, .i_reset, .i_req, .i_wr, .i_addr,
    .i_wdata, .i_ind_wr, .i_ind_data, .o_ack, .o_err, .o_rdata,
    .o_cfg_func, .o_sel_inst);
  function automatic logic [31:0] rnd();
    s = s ^ (s << 13); s = s ^ (s >> 17); s = s ^ (s << 5);
    return s;
  endfunction
  task automatic end_sim();
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, g);
    total_checks++;
    if (g !== x) begin n_fail++; $display("[ERR] %s exp %h got %h", n, x, g); end
  endtask
  // One access; answer awaited under a bound
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge i_ref_clk);
    i_req <= 1; i_wr <= w; i_addr <= a; i_wdata <= d;
    @(posedge i_ref_clk);
    i_req <= 0;
    #1;
    for (k = 0; k < 4 && o_ack !== 1'b1; k++) @(posedge i_ref_clk) #1;
    if (k == 4)
    begin
      n_fail++;
      $display("[ERR] ack exp 1 got %b", o_ack);
      end_sim();
    end
    r = o_rdata; e = o_err;
  endtask
  initial
  begin
    repeat (8) @(posedge i_ref_clk);
    i_reset <= 0;
    foreach (cfg[i]) cfg[i] = 32'h00ff_0000;
    resource_instance_selector = 0; ctx = 0;
    acc(0, 8'h04, 0); chk("cfg_rst", 32'h00ff_0000, r);
    acc(0, 8'h08, 0); chk("id_rst", 32'h8000_1000, r);
    $display("reset test done");
    // Software keeps reserved-one bits at one when writing
    acc(1, 8'h04, 32'h00ff_a5a5);
    acc(0, 8'h04, 0); chk("cfg_should_write_one_or_preserve", 32'h00ff_a5a5, r);
    // Writable reserved bits hold what was written; fixed bits do not
    acc(1, 8'h04, 32'h0f00_0000);
    acc(0, 8'h04, 0); chk("cfg_wr", 32'h0ff0_0000, r);
    cfg[0] = 32'h0ff0_0000;
    $display("corner test done");
    repeat (80)
    begin
      v = rnd();
      case (v[30:28])
        0: begin acc(1, 8'h00, v); resource_instance_selector = v[27:24]; acc(0, 8'h00, 0);
          chk("psel", v & PSEL_MASK, r); end
        1: begin acc(1, 8'h04, v); cfg[resource_instance_selector] = v & 32'h0f0f_ffff | 32'h00f0_0000; end
        2: begin @(posedge i_ref_clk); i_ind_wr <= 1; i_ind_data <= v;
          @(posedge i_ref_clk); i_ind_wr <= 0;
          cfg[resource_instance_selector] = v & 32'hffff | (ctx ? 32'hf000 : 0) | 32'h00ff_0000; end
        3: begin acc(1, 8'h0c, v); ctx = v[0]; end
        4: begin acc(1, 8'h10 | v[1:0], v); chk("err", 1, e); chk("err_rd", 0, r); end
        default: begin acc(0, 8'h08, 0); chk("id", 32'h8000_1000 | resource_instance_selector, r); end
      endcase
      acc(0, 8'h04, 0); chk("cfg", cfg[resource_instance_selector], r);
      chk("func", cfg[resource_instance_selector] & (ctx ? 32'h0fff : 32'hffff), o_cfg_func);
      chk("inst", resource_instance_selector, o_sel_inst);
    end
    $display("random test done");
    end_sim();
  end
endmodule // reserved_bit_field_handling_test
bind rsvb_bank rsvb_bank_assertions rsvb_bank_assertions_i (.i_ref_clk,
  .i_reset, .i_req, .i_wr, .i_addr, .o_ack, .o_err, .o_rdata,
  .o_cfg_func, .o_sel_inst);
`default_nettype wire
